// ===== src/sfc_defs.vh
// sfc_defs.vh: constants of the serial flash command front end
// assumes: included by bare name from the sfc design files
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// opcodes
`define SFC_OP_WR_EN     8'h06
`define SFC_OP_WR_DIS    8'h04
`define SFC_OP_QENTER    8'h35
`define SFC_OP_QEXIT     8'hf5
`define SFC_OP_ERASE64K  8'hd8
`define SFC_OP_READ      8'h03
`define SFC_OP_FREAD     8'h0b
`define SFC_OP_QREAD     8'heb
`define SFC_OP_PROG      8'h02

// serial framing
`define SFC_BYTE_BITS    4'h8
`define SFC_STEP_1       4'h1
`define SFC_STEP_4       4'h4
`define SFC_CNT_ZERO     4'h0
`define SFC_ADDR_LAST    2'h3
// idle pin levels {sclk, cs_n, io}: clock low, deselected, lines low
`define SFC_PIN_IDLE     6'h10

// dummy select field inside the configuration byte
`define SFC_DC_LO_BIT    6
`define SFC_DC_HI_BIT    7
`define SFC_DUMMY_SEL0   5'h06
`define SFC_DUMMY_SEL1   5'h08
`define SFC_DUMMY_SEL2   5'h0a
`define SFC_DUMMY_SEL3   5'h0c

// pin drive masks, enable is active low
`define SFC_OE_NONE      4'hf
`define SFC_OE_QUAD      4'h0
`define SFC_OE_SINGLE    4'hd
`define SFC_SO_LANE      1

`endif

// ===== src/sfc_pin_sync.v
// sfc_pin_sync.v: three-stage synchroniser with agreement filter and edge pulses
// assumes: inputs come from pins outside the sys_clk domain
`default_nettype none

module sfc_pin_sync #(
    parameter         W       = 6,
    parameter [W-1:0] RST_LVL = {W{1'b0}}
) (
    input  wire         sys_clk,
    input  wire         rst_n,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] level_r,
    output reg  [W-1:0] rise_r,
    output reg  [W-1:0] fall_r
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            reg s3_r;
            // first stage feeds only the second; level moves when stages two and three agree
            // reset to the pin's idle level so no false edge follows reset
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r       <= RST_LVL[i];
                    s2_r       <= RST_LVL[i];
                    s3_r       <= RST_LVL[i];
                    level_r[i] <= RST_LVL[i];
                    rise_r[i]  <= 1'b0;
                    fall_r[i]  <= 1'b0;
                end else begin
                    s1_r       <= pin_in[i];
                    s2_r       <= s1_r;
                    s3_r       <= s2_r;
                    rise_r[i]  <= 1'b0;
                    fall_r[i]  <= 1'b0;
                    if (s2_r == s3_r && s3_r != level_r[i]) begin
                        level_r[i] <= s3_r;
                        rise_r[i]  <= s3_r;
                        fall_r[i]  <= ~s3_r;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ===== src/sfc_cmd_core.v
// sfc_cmd_core.v: command interpreter of a serial nor flash, single and quad line
// assumes: sclk, cs_n and io pins are asynchronous and much slower than sys_clk;
// the array behind answers rd_req within one byte time and acts on erase/program pulses
//
// Functional notes
// - every address command carries four address bytes; no three-byte form exists
// - opcode 35h enters quad command mode; quad enable bit is never touched
// - opcode f5h in quad command mode returns to single-line command phases
// - in quad command mode opcode, address and data all use four lines
// - fast read dummy cycles follow configuration bits six and seven
// - opcode d8h plus four address bytes erases a 64k block, both modes
// - unknown opcode: enter ignore state, tri-state outputs, ignore bus until chip select rises
// - non-read commands must end on a byte boundary, else rejected unexecuted
// - input sampled on rising serial clock, output shifted on falling edge
// - program or erase needs write enable latch set by opcode 06h first
`default_nettype none
`include "sfc_defs.vh"

module sfc_cmd_core (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        sclk,
    input  wire        cs_n,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out_r,
    output reg  [3:0]  io_oe_n_r,
    input  wire [7:0]  cfg_reg,
    input  wire [7:0]  rd_data,
    output reg         rd_req_r,
    output reg  [31:0] mem_addr_r,
    output reg         erase_req_r,
    output reg         prog_byte_valid_r,
    output reg  [7:0]  prog_byte_r,
    output reg         prog_commit_r,
    output reg         cmd_reject_r,
    output reg         quad_command_mode_r,
    output reg         write_enable_latch_r
);

    localparam ST_IDLE   = 3'd0;
    localparam ST_OPC    = 3'd1;
    localparam ST_ADDR   = 3'd2;
    localparam ST_DUMMY  = 3'd3;
    localparam ST_DOUT   = 3'd4;
    localparam ST_DIN    = 3'd5;
    localparam ST_TAIL   = 3'd6;
    localparam ST_IGNORE = 3'd7;

    // opcode recognised in the present command mode
    function op_known;
        input [7:0] op;
        input       quad;
        begin
            case (op)
                `SFC_OP_WR_EN, `SFC_OP_WR_DIS, `SFC_OP_ERASE64K,
                `SFC_OP_QREAD, `SFC_OP_PROG:          op_known = 1'b1;
                `SFC_OP_QENTER, `SFC_OP_READ,
                `SFC_OP_FREAD:                        op_known = ~quad;
                `SFC_OP_QEXIT:                        op_known = quad;
                default:                              op_known = 1'b0;
            endcase
        end
    endfunction

    // commands followed by a four-byte address
    function op_has_addr;
        input [7:0] op;
        begin
            op_has_addr = (op == `SFC_OP_ERASE64K) || (op == `SFC_OP_READ) ||
                          (op == `SFC_OP_FREAD) || (op == `SFC_OP_QREAD) ||
                          (op == `SFC_OP_PROG);
        end
    endfunction

    // reads that insert dummy cycles
    function op_has_dummy;
        input [7:0] op;
        begin
            op_has_dummy = (op == `SFC_OP_FREAD) || (op == `SFC_OP_QREAD);
        end
    endfunction

    // pin synchroniser: bit 5 sclk, bit 4 cs_n, bits 3..0 io
    wire [5:0] lvl;
    wire [5:0] rise;
    wire [5:0] fall;

    sfc_pin_sync #(
        .W       (6),
        .RST_LVL (`SFC_PIN_IDLE)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  ({sclk, cs_n, io_in}),
        .level_r (lvl),
        .rise_r  (rise),
        .fall_r  (fall)
    );

    wire       sclk_rise = rise[5];
    wire       sclk_fall = fall[5];
    wire       cs_rise   = rise[4];
    wire       cs_fall   = fall[4];
    wire       cs_act    = ~lvl[4];
    wire [3:0] io_lvl    = lvl[3:0];

    reg [2:0]  st_r;
    reg [7:0]  op_r;
    reg [7:0]  sh_r;
    reg [3:0]  cnt_r;
    reg [1:0]  abyte_r;
    reg [31:0] addr_r;
    reg [4:0]  dcnt_r;
    reg [7:0]  osh_r;
    reg [3:0]  ocnt_r;

    // four-line phases: all phases in quad mode, address on for quad read
    wire wide = quad_command_mode_r |
                ((st_r != ST_OPC) && (op_r == `SFC_OP_QREAD));

    // input shift: one bit or one nibble per rising serial clock
    wire [3:0] step    = wide ? `SFC_STEP_4 : `SFC_STEP_1;
    wire [3:0] cnt_nxt = cnt_r + step;
    wire       byte_dn = (cnt_nxt == `SFC_BYTE_BITS);
    wire [7:0] sh_nxt  = wide ? {sh_r[3:0], io_lvl} : {sh_r[6:0], io_lvl[0]};

    // dummy count from the two-bit select field
    wire [1:0] dsel = {cfg_reg[`SFC_DC_HI_BIT], cfg_reg[`SFC_DC_LO_BIT]};
    reg  [4:0] dummy_n;
    always @* begin
        case (dsel)
            2'h0:    dummy_n = `SFC_DUMMY_SEL0;
            2'h1:    dummy_n = `SFC_DUMMY_SEL1;
            2'h2:    dummy_n = `SFC_DUMMY_SEL2;
            default: dummy_n = `SFC_DUMMY_SEL3;
        endcase
    end

    // output source: fresh array byte when the previous one is spent
    wire [7:0] osrc     = (ocnt_r == `SFC_CNT_ZERO) ? rd_data : osh_r;
    wire [3:0] ocnt_nxt = ocnt_r + step;

    // frame end is clean when no partial byte is pending
    wire on_bound = (cnt_r == `SFC_CNT_ZERO);

    // main sequencer
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r                 <= ST_IDLE;
            op_r                 <= 8'h00;
            sh_r                 <= 8'h00;
            cnt_r                <= 4'h0;
            abyte_r              <= 2'h0;
            addr_r               <= 32'h0000_0000;
            dcnt_r               <= 5'h00;
            osh_r                <= 8'h00;
            ocnt_r               <= 4'h0;
            io_out_r             <= 4'h0;
            io_oe_n_r            <= `SFC_OE_NONE;
            rd_req_r             <= 1'b0;
            mem_addr_r           <= 32'h0000_0000;
            erase_req_r          <= 1'b0;
            prog_byte_valid_r    <= 1'b0;
            prog_byte_r          <= 8'h00;
            prog_commit_r        <= 1'b0;
            cmd_reject_r         <= 1'b0;
            quad_command_mode_r  <= 1'b0;
            write_enable_latch_r <= 1'b0;
        end else begin
            rd_req_r          <= 1'b0;
            erase_req_r       <= 1'b0;
            prog_byte_valid_r <= 1'b0;
            prog_commit_r     <= 1'b0;
            cmd_reject_r      <= 1'b0;
            if (cs_rise) begin
                // end of frame: execute or reject, then release the pins
                st_r      <= ST_IDLE;
                io_oe_n_r <= `SFC_OE_NONE;
                if ((st_r == ST_TAIL || st_r == ST_DIN) && on_bound) begin
                    case (op_r)
                        `SFC_OP_WR_EN:  write_enable_latch_r <= 1'b1;
                        `SFC_OP_WR_DIS: write_enable_latch_r <= 1'b0;
                        // quad enable bit has no write path here
                        `SFC_OP_QENTER: quad_command_mode_r <= 1'b1;
                        `SFC_OP_QEXIT:  quad_command_mode_r <= 1'b0;
                        `SFC_OP_ERASE64K: begin
                            if (write_enable_latch_r) begin
                                erase_req_r          <= 1'b1;
                                write_enable_latch_r <= 1'b0;
                            end else begin
                                cmd_reject_r <= 1'b1;
                            end
                        end
                        `SFC_OP_PROG: begin
                            if (write_enable_latch_r) begin
                                prog_commit_r        <= 1'b1;
                                write_enable_latch_r <= 1'b0;
                            end else begin
                                cmd_reject_r <= 1'b1;
                            end
                        end
                        default: cmd_reject_r <= 1'b0;
                    endcase
                end else if (st_r == ST_TAIL || st_r == ST_DIN || st_r == ST_ADDR ||
                             (st_r == ST_OPC && !on_bound)) begin
                    cmd_reject_r <= 1'b1;
                end
            end else if (cs_fall) begin
                // first byte of every frame is the opcode
                st_r    <= ST_OPC;
                cnt_r   <= 4'h0;
                abyte_r <= 2'h0;
                ocnt_r  <= 4'h0;
            end else if (cs_act && sclk_rise) begin
                // sample inputs on the rising serial clock
                case (st_r)
                    ST_OPC: begin
                        sh_r  <= sh_nxt;
                        cnt_r <= byte_dn ? `SFC_CNT_ZERO : cnt_nxt;
                        if (byte_dn) begin
                            op_r <= sh_nxt;
                            if (!op_known(sh_nxt, quad_command_mode_r)) begin
                                st_r      <= ST_IGNORE;
                                io_oe_n_r <= `SFC_OE_NONE;
                            end else if (op_has_addr(sh_nxt)) begin
                                st_r <= ST_ADDR;
                            end else begin
                                st_r <= ST_TAIL;
                            end
                        end
                    end
                    ST_ADDR: begin
                        sh_r  <= sh_nxt;
                        cnt_r <= byte_dn ? `SFC_CNT_ZERO : cnt_nxt;
                        if (byte_dn) begin
                            addr_r  <= {addr_r[23:0], sh_nxt};
                            abyte_r <= abyte_r + 2'h1;
                            if (abyte_r == `SFC_ADDR_LAST) begin
                                mem_addr_r <= {addr_r[23:0], sh_nxt};
                                dcnt_r     <= 5'h00;
                                if (op_r == `SFC_OP_ERASE64K) begin
                                    st_r <= ST_TAIL;
                                end else if (op_r == `SFC_OP_PROG) begin
                                    st_r <= ST_DIN;
                                end else begin
                                    rd_req_r <= 1'b1;
                                    st_r     <= op_has_dummy(op_r) ? ST_DUMMY : ST_DOUT;
                                end
                            end
                        end
                    end
                    ST_DUMMY: begin
                        dcnt_r <= dcnt_r + 5'h01;
                        if (dcnt_r + 5'h01 == dummy_n) begin
                            st_r <= ST_DOUT;
                        end
                    end
                    ST_DIN: begin
                        sh_r  <= sh_nxt;
                        cnt_r <= byte_dn ? `SFC_CNT_ZERO : cnt_nxt;
                        if (byte_dn) begin
                            prog_byte_valid_r <= 1'b1;
                            prog_byte_r       <= sh_nxt;
                        end
                    end
                    ST_TAIL: begin
                        // extra bits only matter for the boundary check
                        cnt_r <= byte_dn ? `SFC_CNT_ZERO : cnt_nxt;
                    end
                    default: st_r <= st_r;
                endcase
            end else if (cs_act && sclk_fall && st_r == ST_DOUT) begin
                // shift data out on the falling serial clock
                ocnt_r <= (ocnt_nxt == `SFC_BYTE_BITS) ? `SFC_CNT_ZERO : ocnt_nxt;
                if (wide) begin
                    io_out_r  <= osrc[7:4];
                    osh_r     <= {osrc[3:0], 4'h0};
                    io_oe_n_r <= `SFC_OE_QUAD;
                end else begin
                    io_out_r                <= 4'h0;
                    io_out_r[`SFC_SO_LANE]  <= osrc[7];
                    osh_r                   <= {osrc[6:0], 1'b0};
                    io_oe_n_r               <= `SFC_OE_SINGLE;
                end
                if (ocnt_r == `SFC_CNT_ZERO) begin
                    mem_addr_r <= mem_addr_r + 32'h0000_0001;
                    rd_req_r   <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/sfc_cmd_core_properties.sv
// sfc_cmd_core_properties.sv: timing checks on the command core ports
// assumes: bound into every sfc_cmd_core instance, one clock domain
`default_nettype none
module sfc_cmd_core_properties (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] io_out_r,
    input wire logic [3:0] io_oe_n_r,
    input wire logic       rd_req_r,
    input wire logic       erase_req_r,
    input wire logic       prog_commit_r,
    input wire logic       cmd_reject_r,
    input wire logic       quad_command_mode_r,
    input wire logic       write_enable_latch_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // pins released a while after deselect
    AST_IDLE_RELEASE: assert property (cs_n [*8] |-> io_oe_n_r == 4'hf)
        else $error("io driven while deselected");
    AST_OE_CODES: assert property (io_oe_n_r inside {4'hf, 4'hd, 4'h0})
        else $error("odd drive mask");
    AST_QUAD_LINES: assert property (quad_command_mode_r |-> io_oe_n_r != 4'hd)
        else $error("single line drive in quad mode");
    AST_ERASE_WEL: assert property (erase_req_r |-> $past(write_enable_latch_r) ##1 !write_enable_latch_r)
        else $error("erase without latch or latch kept");
    AST_PULSE_AT_END: assert property (erase_req_r || prog_commit_r || cmd_reject_r |-> cs_n && $past(cs_n, 2))
        else $error("action while selected");
    AST_ONE_ACTION: assert property (erase_req_r |-> !cmd_reject_r && !prog_commit_r ##1 !erase_req_r)
        else $error("erase pulse clash");
    AST_MODE_AT_END: assert property ($changed(quad_command_mode_r) |-> cs_n && $stable(write_enable_latch_r))
        else $error("mode change mid frame");
    AST_OUT_ON_FALL: assert property ($changed(io_out_r) && !cs_n |-> !sclk)
        else $error("output moved while clock high");
    AST_WEL_SET: assert property ($rose(write_enable_latch_r) |-> cs_n && !cmd_reject_r)
        else $error("latch set on bad frame");
    AST_REQ_IN_FRAME: assert property (rd_req_r |-> !cs_n && !$past(cs_n, 4))
        else $error("array request outside a frame");
    // main scenarios
    CVR_ERASE: cover property (erase_req_r);
    CVR_REJECT: cover property (cmd_reject_r);
    CVR_QUAD_ON: cover property ($rose(quad_command_mode_r));
    CVR_QUAD_READ: cover property (rd_req_r && io_oe_n_r == 4'h0);
endmodule
bind sfc_cmd_core sfc_cmd_core_properties i_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .io_out_r(io_out_r), .io_oe_n_r(io_oe_n_r),
    .rd_req_r(rd_req_r), .erase_req_r(erase_req_r), .prog_commit_r(prog_commit_r),
    .cmd_reject_r(cmd_reject_r), .quad_command_mode_r(quad_command_mode_r),
    .write_enable_latch_r(write_enable_latch_r));
`default_nettype wire

// ===== tb/sfc_host_model.sv
// sfc_host_model.sv: serial host for the flash command core
// assumes: paced by sys_clk falls; the bench calls its tasks
`default_nettype none
module sfc_host_model (
    input  wire logic       sys_clk,
    input  wire logic [3:0] io_out_r,
    input  wire logic [3:0] io_oe_n_r,
    output var  logic       sclk,
    output var  logic       cs_n,
    output wire logic [3:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  hd = 4'h0;
    logic [31:0] cap = 32'h0;
    // pin level: core drives where its enable is low
    assign io_in = (io_out_r & ~io_oe_n_r) | (hd & io_oe_n_r);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // half of the 160 ns link period
    task automatic half();
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic start();
        cs_n = 1'b0;
        half();
    endtask
    // msb first on one or four lines; wire sampled just before each rise
    task automatic shift(input logic [63:0] v, input int nb, input bit q);
        for (int i = 0; i < nb; i += q ? 4 : 1) begin
            hd = q ? v[nb-1-i -: 4] : {~hd[3:1], v[nb-1-i]};
            half();
            cap = q ? {cap[27:0], io_in} : {cap[30:0], io_in[1]};
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask
    // half a period, deselect, host lines inverted, then the deselect time
    task automatic stop();
        half();
        cs_n = 1'b1;
        hd = ~hd;
        repeat (4) half();
    endtask
endmodule
`default_nettype wire

// ===== tb/test_serial_flash_cmd_protocol.sv
// test_serial_flash_cmd_protocol.sv: self-checking bench of the command core
// assumes: core, host model and checker compiled first
`default_nettype none
`include "sfc_defs.vh"
module test_serial_flash_cmd_protocol;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, sclk, cs_n, rd_req_r, erase_req_r, prog_byte_valid_r;
    logic        prog_commit_r, cmd_reject_r, quad_command_mode_r, write_enable_latch_r;
    logic [3:0]  io_in, io_out_r, io_oe_n_r;
    logic [7:0]  cfg_reg, rd_data, prog_byte_r;
    logic [31:0] mem_addr_r, a;
    int          n_errors = 0, checks = 0, n_ers, n_rej, n_prg, n_cmt;
    sfc_cmd_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .io_in(io_in), .io_out_r(io_out_r), .io_oe_n_r(io_oe_n_r), .cfg_reg(cfg_reg),
        .rd_data(rd_data), .rd_req_r(rd_req_r), .mem_addr_r(mem_addr_r),
        .erase_req_r(erase_req_r), .prog_byte_valid_r(prog_byte_valid_r),
        .prog_byte_r(prog_byte_r), .prog_commit_r(prog_commit_r),
        .cmd_reject_r(cmd_reject_r), .quad_command_mode_r(quad_command_mode_r),
        .write_enable_latch_r(write_enable_latch_r));
    sfc_host_model i_host (.sys_clk(sys_clk), .io_out_r(io_out_r),
        .io_oe_n_r(io_oe_n_r), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));
    // array stand-in: byte derived from its address
    assign rd_data = mem_addr_r[7:0] ^ 8'h5a;
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // counts the one-cycle action pulses
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {n_ers, n_rej, n_prg, n_cmt} <= '0;
        end else begin
            n_ers <= n_ers + int'(erase_req_r);
            n_rej <= n_rej + int'(cmd_reject_r);
            n_prg <= n_prg + int'(prog_byte_valid_r);
            n_cmt <= n_cmt + int'(prog_commit_r);
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic frame(input logic [7:0] op, input int nb, input logic [31:0] ad, input bit q);
        i_host.start();
        i_host.shift(op, 8, q);
        i_host.shift(ad, nb, q);
        i_host.stop();
    endtask
    // read of two bytes after the dummy cycles
    task automatic rd(input logic [7:0] op, input logic [31:0] ad, input int nd, input bit q);
        bit w;
        w = q | (op == `SFC_OP_QREAD);
        i_host.start();
        i_host.shift(op, 8, q);
        i_host.shift(ad, 32, w);
        i_host.shift(0, w ? 4 * nd : nd, w);
        i_host.shift(0, 16, w);
        i_host.stop();
        chk("read", i_host.cap[15:0], {ad[7:0] ^ 8'h5a, (ad[7:0] + 8'h01) ^ 8'h5a});
    endtask
    task automatic stop_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        cfg_reg = 8'h00;
        repeat (8) @(negedge sys_clk);
        chk("oe reset", io_oe_n_r, `SFC_OE_NONE);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        frame(`SFC_OP_ERASE64K, 32, 32'h0001_0000, 0);
        chk("reject", n_rej, 1);
        frame(`SFC_OP_WR_EN, 3, 32'h5, 0);
        chk("reject", n_rej, 2);
        chk("latch", write_enable_latch_r, 0);
        for (int m = 0; m < 2; m++) begin
            a = 32'h1234_5678 + m * 32'h0101_0101;
            frame(`SFC_OP_WR_EN, 0, 0, m[0]);
            chk("latch", write_enable_latch_r, 1);
            frame(`SFC_OP_ERASE64K, 24, a, m[0]);
            chk("reject", n_rej, 3 + m);
            frame(`SFC_OP_ERASE64K, 32, a, m[0]);
            chk("erase", n_ers, m + 1);
            chk("addr", mem_addr_r, a);
            chk("latch", write_enable_latch_r, 0);
            for (int k = 0; k < 4; k++) begin
                cfg_reg = {k[1:0], 6'h0};
                rd(m[0] ? `SFC_OP_QREAD : `SFC_OP_FREAD, a + k, 6 + 2 * k, m[0]);
            end
            frame(8'h9f, 32, {`SFC_OP_WR_EN, 24'h0}, m[0]);
            chk("latch", write_enable_latch_r, 0);
            chk("reject", n_rej, 3 + m);
            frame(`SFC_OP_QENTER, 0, 0, m[0]);
            chk("quad", quad_command_mode_r, 1);
        end
        frame(`SFC_OP_QEXIT, 0, 0, 1);
        chk("quad", quad_command_mode_r, 0);
        frame(`SFC_OP_QEXIT, 0, 0, 0);
        chk("quad", quad_command_mode_r, 0);
        // single-line opcode, then address, dummy and data on four lines
        rd(`SFC_OP_QREAD, a, 12, 0);
        rd(`SFC_OP_READ, a, 0, 0);
        frame(`SFC_OP_WR_EN, 0, 0, 0);
        i_host.start();
        i_host.shift(`SFC_OP_PROG, 8, 0);
        i_host.shift(a, 32, 0);
        i_host.shift(16'hc35a, 16, 0);
        i_host.stop();
        chk("prog bytes", n_prg, 2);
        chk("prog last", prog_byte_r, 8'h5a);
        chk("commit", n_cmt, 1);
        stop_test();
    end
    // cuts a hang short well past the expected run of about 130 us
    initial begin
        #600us;
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
